// [rtl/wac_pkg.sv]
// Shared constants and types for the waveform accumulation control block
package wac_pkg;
	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_KNOB   = 8'h04;
	localparam logic [7:0] REG_CHANGE = 8'h08;
	localparam logic [7:0] REG_EXPAND = 8'h0c;
	localparam logic [7:0] REG_POS    = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_DISP   = 8'h18;
	localparam logic [7:0] REG_WINDOW = 8'h1c;

	// Control, knob, expansion and position register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_WIN_BIT    = 2;
	localparam int CTRL_CHOP_BIT   = 3;
	localparam int CTRL_FAST_BIT   = 4;
	localparam int CTRL_SMOOTH_BIT = 5;
	localparam int CTRL_FREEZE_BIT = 6;
	localparam int CTRL_REF_BIT    = 7;
	localparam int CTRL_SEL_BIT    = 8;
	localparam int KNOB_CW_BIT     = 0;
	localparam int KNOB_CCW_BIT    = 1;
	localparam int EXP_HFAC_LSB    = 0;
	localparam int EXP_VFAC_LSB    = 8;
	localparam int POS_H_LSB       = 0;
	localparam int POS_V_LSB       = 8;

	// Acquisition modes as held in the control register
	localparam logic [1:0] MODE_LIVE = 2'h0;
	localparam logic [1:0] MODE_ENV  = 2'h1;
	localparam logic [1:0] MODE_MEAN = 2'h2;

	// Sweep count held as a power-of-two exponent
	localparam logic [3:0] EXP_RESET    = 4'h5;
	localparam logic [3:0] EXP_ENV_MIN  = 4'h0;
	localparam logic [3:0] EXP_MEAN_MIN = 4'h1;
	localparam logic [3:0] EXP_MAX      = 4'h8;
	localparam logic [3:0] EXP_UNLIM    = 4'h9;
	localparam logic [15:0] UNLIM_SHOW  = 16'h270f;

	// Expansion of frozen data
	localparam logic [6:0] TRIG_PT_LATE = 7'h40;
	localparam logic [6:0] TRIG_PT_CHOP = 7'h20;
	localparam logic [6:0] HEXP_MAX     = 7'h64;
	localparam logic [3:0] VEXP_MAX     = 4'ha;

	// Cycle sequencing states
	typedef enum logic [1:0] {WAC_RUN, WAC_PEND, WAC_FROZEN} wac_state_e;
endpackage

// [rtl/wac_sync.sv]
// Three-stage pin synchroniser that accepts a change once two late stages agree
`timescale 1ns/1ps
module wac_sync
	import wac_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	if (W < 1) begin : g_chk
		$error("wac_sync: width must be at least one");
	end

	// Stage chain; the first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accept a level only when stages two and three agree, filtering one-cycle glitches
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_out <= '0;
		end else begin
			level_out <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_out);
		end
	end
endmodule

// [rtl/wac_expand.sv]
// Expansion settings applied to frozen waveform data
`timescale 1ns/1ps
module wac_expand
	import wac_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       frozen,
	input  wire logic       chop_held,
	input  wire logic [6:0] hreq,
	input  wire logic [3:0] vreq,
	output logic      [6:0] center,
	output logic      [6:0] hfac,
	output logic      [3:0] vfac
);
	// Clamp a request into 1..limit; zero reads as unity
	function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lim);
		clamp7 = (v == 7'h00) ? 7'h01 : ((v > lim) ? lim : v);
	endfunction

	// Live data is never expanded, so factors sit at unity outside freeze
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			center <= TRIG_PT_LATE;
			hfac   <= 7'h01;
			vfac   <= 4'h1;
		end else begin
			center <= chop_held ? TRIG_PT_CHOP : TRIG_PT_LATE; // RULE16 RULE17
			hfac   <= frozen ? clamp7(hreq, HEXP_MAX) : 7'h01; // RULE16
			vfac   <= frozen ? 4'(clamp7({3'h0, vreq}, {3'h0, VEXP_MAX})) : 4'h1; // RULE18
		end
	end
endmodule

// [rtl/wac_top.sv]
// Sweep accumulation, freeze and reference-hold sequencing for a storage acquisition system
// Notes on behaviour
// RULE1: Power-on sweep count is 32 for both envelope and averaging.
// RULE2: Envelope count steps in powers of two from 1 to 256.
// RULE3: Averaging count steps in powers of two from 2 to 256.
// RULE4: Envelope offers unlimited count shown as 9999; runs until count or control changes.
// RULE5: With unlimited count the display holds instead of counting down.
// RULE6: Finite envelope updates each sweep, then clears and restarts at count, forever.
// RULE7: Averaging gathers full count, publishes, and keeps accumulating the next average.
// RULE8: Any acquisition-affecting control change restarts accumulation from zero sweeps.
// RULE9: After select release, display counts down for the first cycle, then yields.
// RULE10: Counting starts when a new count is chosen, even with select held.
// RULE11: Early window puts 7/8 of record before trigger; late window 7/8 after.
// RULE12: Freeze during live or unlimited envelope stops at once, keeping display.
// RULE13: Freeze during finite cycle finishes that cycle, then stops keeping the result.
// RULE14: Control change while freeze is pending restarts the pending cycle.
// RULE15: Unlimited envelope enters freeze immediately on request.
// RULE16: Frozen data expands horizontally up to 100x about sample 64.
// RULE17: Chopped frozen records use sample 32 as the expansion centre; the code applies it only to records frozen in live mode.
// RULE18: Frozen data expands vertically up to 10x per channel setting.
// RULE19: Each reference press captures anew; release removes the reference.
// RULE20: Reference ignores all changes except horizontal position; keeps vertical position.
// RULE21: Fast-timebase averaged display applies the selected interpolation response.
// RULE22: Knob clockwise doubles count, counterclockwise halves, clamped at mode limits.
`timescale 1ns/1ps
module wac_top
	import wac_pkg::*;
#(
	parameter int REC_LEN = 512,
	parameter int REC_W   = $clog2(REC_LEN + 1)
) (
	input  wire logic              CLK_SYS,
	input  wire logic              RSTN,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	input  wire logic              SWEEP_END,
	output logic                   ACQ_RUN,
	output logic                   RESULT_UPDATE,
	output logic                   RESULT_CLEAR,
	output logic                   MEAN_PUBLISH,
	output logic      [REC_W-1:0]  PRETRIG_CNT,
	output logic      [15:0]       DISP_VALUE,
	output logic                   DISP_COUNT_OWN,
	output logic                   REF_CAPTURE,
	output logic                   REF_SHOW,
	output logic      [7:0]        REF_VPOS,
	output logic      [7:0]        REF_HPOS,
	output logic                   INTERP_SMOOTH,
	output logic      [6:0]        HEXP_CENTER,
	output logic      [6:0]        HEXP_FACTOR,
	output logic      [3:0]        VEXP_FACTOR
);
	// Record must hold the expansion centre and split cleanly into eighths
	if (REC_LEN < 128 || (REC_LEN % 8) != 0) begin : g_chk
		$error("wac_top: REC_LEN must be a multiple of 8 and at least 128");
	end
	localparam logic [REC_W-1:0] PRE_EARLY = REC_W'((REC_LEN * 7) / 8);
	localparam logic [REC_W-1:0] PRE_LATE  = REC_W'(REC_LEN / 8);
	// Lowest and highest exponent allowed in a mode
	function automatic logic [3:0] exp_min(input logic [1:0] m);
		exp_min = (m == MODE_MEAN) ? EXP_MEAN_MIN : EXP_ENV_MIN; // RULE2 RULE3
	endfunction
	function automatic logic [3:0] exp_max(input logic [1:0] m);
		exp_max = (m == MODE_ENV) ? EXP_UNLIM : EXP_MAX; // RULE4
	endfunction
	// Pull an exponent back inside the current mode's range
	function automatic logic [3:0] exp_clamp(input logic [3:0] e, input logic [1:0] m);
		exp_clamp = (e < exp_min(m)) ? exp_min(m) : ((e > exp_max(m)) ? exp_max(m) : e);
	endfunction
	// Control, expansion and position register contents
	logic [1:0] mode_r;
	logic       win_r;
	logic       chop_r;
	logic       fast_r;
	logic       smooth_r;
	logic       freeze_r;
	logic       ref_r;
	logic       sel_r;
	logic [6:0] hreq_r;
	logic [3:0] vreq_r;
	logic [7:0] hpos_r;
	logic [7:0] vpos_r;
	// Edge history and sequencing state
	logic       freeze_prev_r;
	logic       ref_prev_r;
	logic       sel_prev_r;
	logic       sw_prev_r;
	logic       chg_r;
	logic       step_r;
	logic [3:0] exp_r;
	logic [8:0] done_r;
	logic       own_r;
	logic       released_r;
	logic       chop_held_r;
	wac_state_e state_r;
	wac_state_e state_nxt;
	logic       wr_ctrl;
	logic       wr_knob;
	logic       knob_cw;
	logic       knob_ccw;
	logic       ctrl_chg;
	logic       sw_lvl;
	logic       sweep_ev;
	logic       unlim;
	logic [8:0] cnt_val;
	logic       last;
	logic       accum;
	logic       cycle_done;
	logic       freeze_rise;
	logic       freeze_fall;
	// Sweep-end pin arrives from the gate logic outside this clock domain
	wac_sync #(
		.W(1)
	) u_sync (
		.clk      (CLK_SYS),
		.rstn     (RSTN),
		.pin_in   (SWEEP_END),
		.level_out(sw_lvl)
	);
	// Write decode and control changes that alter acquired data
	always_comb begin
		wr_ctrl  = WR && (ADDR == REG_CTRL);
		wr_knob  = WR && (ADDR == REG_KNOB);
		knob_cw  = wr_knob && WDATA[KNOB_CW_BIT];
		knob_ccw = wr_knob && WDATA[KNOB_CCW_BIT];
		ctrl_chg = wr_ctrl && ((WDATA[CTRL_MODE_LSB +: 2] != mode_r) || (WDATA[CTRL_WIN_BIT] != win_r) ||
			(WDATA[CTRL_CHOP_BIT] != chop_r) || (WDATA[CTRL_FAST_BIT] != fast_r));
	end
	// Control, expansion and position registers
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mode_r   <= MODE_LIVE;
			win_r    <= 1'b0;
			chop_r   <= 1'b0;
			fast_r   <= 1'b0;
			smooth_r <= 1'b0;
			freeze_r <= 1'b0;
			ref_r    <= 1'b0;
			sel_r    <= 1'b0;
			hreq_r   <= 7'h01;
			vreq_r   <= 4'h1;
			hpos_r   <= 8'h00;
			vpos_r   <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				mode_r   <= (WDATA[CTRL_MODE_LSB +: 2] > MODE_MEAN) ? MODE_LIVE : WDATA[CTRL_MODE_LSB +: 2];
				win_r    <= WDATA[CTRL_WIN_BIT];
				chop_r   <= WDATA[CTRL_CHOP_BIT];
				fast_r   <= WDATA[CTRL_FAST_BIT];
				smooth_r <= WDATA[CTRL_SMOOTH_BIT];
				freeze_r <= WDATA[CTRL_FREEZE_BIT];
				ref_r    <= WDATA[CTRL_REF_BIT];
				sel_r    <= WDATA[CTRL_SEL_BIT];
			end
			if (WR && (ADDR == REG_EXPAND)) begin
				hreq_r <= WDATA[EXP_HFAC_LSB +: 7];
				vreq_r <= WDATA[EXP_VFAC_LSB +: 4];
			end
			if (WR && (ADDR == REG_POS)) begin
				hpos_r <= WDATA[POS_H_LSB +: 8];
				vpos_r <= WDATA[POS_V_LSB +: 8];
			end
		end
	end
	// Edge history of the button bits and the synchronised sweep level
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			freeze_prev_r <= 1'b0;
			ref_prev_r    <= 1'b0;
			sel_prev_r    <= 1'b0;
			sw_prev_r     <= 1'b0;
		end else begin
			freeze_prev_r <= freeze_r;
			ref_prev_r    <= ref_r;
			sel_prev_r    <= sel_r;
			sw_prev_r     <= sw_lvl;
		end
	end
	// Sweep count exponent; a knob step doubles or halves within the mode's range
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			exp_r <= EXP_RESET; // RULE1
		end else if (knob_cw && !knob_ccw) begin
			exp_r <= (exp_r >= exp_max(mode_r)) ? exp_max(mode_r) : exp_clamp(exp_r + 4'h1, mode_r); // RULE22
		end else if (knob_ccw && !knob_cw) begin
			exp_r <= (exp_r <= exp_min(mode_r)) ? exp_min(mode_r) : exp_clamp(exp_r - 4'h1, mode_r); // RULE22
		end else begin
			exp_r <= exp_clamp(exp_r, mode_r); // RULE2 RULE3
		end
	end
	// Restart and new-selection pulses, one cycle after the write that caused them
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			chg_r  <= 1'b0;
			step_r <= 1'b0;
		end else begin
			chg_r  <= ctrl_chg || (WR && (ADDR == REG_CHANGE)) || knob_cw || knob_ccw; // RULE8
			step_r <= knob_cw ^ knob_ccw; // RULE10
		end
	end
	// Derived sweep terms
	always_comb begin
		sweep_ev    = sw_lvl && !sw_prev_r;
		unlim       = (mode_r == MODE_ENV) && (exp_r == EXP_UNLIM); // RULE4
		cnt_val     = 9'h001 << exp_r;
		last        = !unlim && (done_r == (cnt_val - 9'h001));
		accum       = (state_r != WAC_FROZEN) && (mode_r != MODE_LIVE);
		cycle_done  = accum && sweep_ev && last && !chg_r;
		freeze_rise = freeze_r && !freeze_prev_r;
		freeze_fall = !freeze_r && freeze_prev_r;
	end
	// Freeze sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			WAC_RUN: begin
				if (freeze_rise && ((mode_r == MODE_LIVE) || unlim)) begin
					state_nxt = WAC_FROZEN; // RULE12 RULE15
				end else if (freeze_rise) begin
					state_nxt = WAC_PEND; // RULE13
				end
			end
			WAC_PEND: begin
				if (freeze_fall) begin
					state_nxt = WAC_RUN;
				end else if (cycle_done || unlim || (mode_r == MODE_LIVE)) begin
					state_nxt = WAC_FROZEN; // RULE13
				end
			end
			WAC_FROZEN: state_nxt = freeze_fall ? WAC_RUN : WAC_FROZEN;
			default: state_nxt = WAC_RUN;
		endcase
	end
	// Sequencing state register
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= WAC_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end
	// Record channel arrangement at freeze entry so later changes cannot shift the centre
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			chop_held_r <= 1'b0;
		end else if (state_r != WAC_FROZEN && state_nxt == WAC_FROZEN) begin
			chop_held_r <= chop_r && (mode_r == MODE_LIVE); // RULE17
		end
	end
	// Sweep counter within the current cycle; a restart beats a coincident sweep
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			done_r <= 9'h000;
		end else if (chg_r || freeze_fall) begin
			done_r <= 9'h000; // RULE8 RULE14
		end else if (accum && sweep_ev && !unlim) begin
			done_r <= last ? 9'h000 : done_r + 9'h001; // RULE6 RULE7
		end
	end
	// Result strobes towards the waveform memory
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			RESULT_UPDATE <= 1'b0;
			RESULT_CLEAR  <= 1'b0;
			MEAN_PUBLISH  <= 1'b0;
			ACQ_RUN       <= 1'b1;
		end else begin
			ACQ_RUN       <= (state_nxt != WAC_FROZEN); // RULE12
			RESULT_UPDATE <= sweep_ev && (state_r != WAC_FROZEN) && (mode_r != MODE_MEAN); // RULE6
			RESULT_CLEAR  <= chg_r || (cycle_done && (mode_r == MODE_ENV)); // RULE6 RULE8
			MEAN_PUBLISH  <= cycle_done && (mode_r == MODE_MEAN); // RULE7
		end
	end
	// Display ownership: taken on press or new selection, handed back after first cycle past release, or at once in live mode
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			own_r      <= 1'b0;
			released_r <= 1'b0;
		end else if ((sel_r && !sel_prev_r) || step_r) begin
			own_r      <= 1'b1; // RULE10
			released_r <= 1'b0;
		end else if (!sel_r && sel_prev_r) begin
			released_r <= own_r;
		end else if (released_r && (cycle_done || (mode_r == MODE_LIVE))) begin
			own_r      <= 1'b0; // RULE9
			released_r <= 1'b0;
		end
	end
	// Numeric display: remaining sweeps, or the unlimited marker held still
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			DISP_VALUE     <= 16'h0000;
			DISP_COUNT_OWN <= 1'b0;
		end else begin
			DISP_COUNT_OWN <= own_r;
			if (unlim) begin
				DISP_VALUE <= UNLIM_SHOW; // RULE5
			end else begin
				DISP_VALUE <= {7'h00, cnt_val - done_r}; // RULE9
			end
		end
	end
	// Reference hold: new capture per press, vertical position frozen at capture
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			REF_CAPTURE <= 1'b0;
			REF_SHOW    <= 1'b0;
			REF_VPOS    <= 8'h00;
			REF_HPOS    <= 8'h00;
		end else begin
			REF_CAPTURE <= ref_r && !ref_prev_r; // RULE19
			REF_SHOW    <= ref_r; // RULE19
			REF_HPOS    <= hpos_r; // RULE20
			if (ref_r && !ref_prev_r) begin
				REF_VPOS <= vpos_r; // RULE20
			end
		end
	end
	// Storage window split and interpolation response selection
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			PRETRIG_CNT   <= PRE_EARLY;
			INTERP_SMOOTH <= 1'b0;
		end else begin
			PRETRIG_CNT   <= win_r ? PRE_LATE : PRE_EARLY; // RULE11
			INTERP_SMOOTH <= fast_r && smooth_r && (mode_r == MODE_MEAN); // RULE21
		end
	end
	// Expansion of frozen data is kept apart since it only reads settled values
	wac_expand u_expand (
		.clk      (CLK_SYS),
		.rstn     (RSTN),
		.frozen   (state_r == WAC_FROZEN),
		.chop_held(chop_held_r),
		.hreq     (hreq_r),
		.vreq     (vreq_r),
		.center   (HEXP_CENTER),
		.hfac     (HEXP_FACTOR),
		.vfac     (VEXP_FACTOR)
	);
	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= '0;
		end else if (!RD) begin
			RDATA <= '0;
		end else if (ADDR == REG_CTRL) begin
			RDATA <= {23'h0, sel_r, ref_r, freeze_r, smooth_r, fast_r, chop_r, win_r, mode_r};
		end else if (ADDR == REG_EXPAND) begin
			RDATA <= {20'h0, vreq_r, 1'b0, hreq_r};
		end else if (ADDR == REG_POS) begin
			RDATA <= {16'h0, vpos_r, hpos_r};
		end else if (ADDR == REG_STATUS) begin
			RDATA <= {14'h0, REF_SHOW, own_r, state_r == WAC_PEND, state_r == WAC_FROZEN, unlim, exp_r, done_r};
		end else if (ADDR == REG_DISP) begin
			RDATA <= {15'h0, DISP_COUNT_OWN, DISP_VALUE};
		end else if (ADDR == REG_WINDOW) begin
			RDATA <= DATA_W'(PRETRIG_CNT);
		end else begin
			RDATA <= '0;
		end
	end
endmodule

// [verif/wac_top_sva.sv]
// Port checker for the accumulation control block
`timescale 1ns/1ps
module wac_top_sva
	import wac_pkg::*;
#(
	parameter int REC_LEN = 512,
	parameter int REC_W   = $clog2(REC_LEN + 1)
) (
	input wire logic             CLK_SYS,
	input wire logic             RSTN,
	input wire logic             WR,
	input wire logic             ACQ_RUN,
	input wire logic             RESULT_UPDATE,
	input wire logic             RESULT_CLEAR,
	input wire logic             MEAN_PUBLISH,
	input wire logic [REC_W-1:0] PRETRIG_CNT,
	input wire logic [15:0]      DISP_VALUE,
	input wire logic             REF_CAPTURE,
	input wire logic [7:0]       REF_VPOS,
	input wire logic [6:0]       HEXP_CENTER,
	input wire logic [6:0]       HEXP_FACTOR,
	input wire logic [3:0]       VEXP_FACTOR
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	// Window split is one of two fixed eighths of the record
	a_window_split: assert property (
		PRETRIG_CNT == REC_W'(REC_LEN * 7 / 8) || PRETRIG_CNT == REC_W'(REC_LEN / 8))
		else $error("pretrigger count outside both windows");
	a_count_range: assert property (
		DISP_VALUE <= 16'h0100 || DISP_VALUE == UNLIM_SHOW)
		else $error("display count out of range");
	// A write two cycles back may legally move the display, so only quiet spells are held
	a_unlim_hold: assert property (
		(DISP_VALUE == UNLIM_SHOW && !$past(WR)) |=> DISP_VALUE == UNLIM_SHOW)
		else $error("unlimited display changed");
	a_hexp_bound: assert property (
		HEXP_FACTOR >= 7'h01 && HEXP_FACTOR <= HEXP_MAX)
		else $error("horizontal factor out of range");
	a_vexp_bound: assert property (
		VEXP_FACTOR >= 4'h1 && VEXP_FACTOR <= VEXP_MAX)
		else $error("vertical factor out of range");
	a_center_pick: assert property (
		HEXP_CENTER == TRIG_PT_LATE || HEXP_CENTER == TRIG_PT_CHOP)
		else $error("expansion centre not a trigger point");
	a_frozen_quiet: assert property (
		!ACQ_RUN [*3] |-> !RESULT_UPDATE && !MEAN_PUBLISH)
		else $error("result activity while stopped");
	a_capture_pulse: assert property (
		REF_CAPTURE |=> !REF_CAPTURE)
		else $error("capture longer than one cycle");
	a_vpos_latched: assert property (
		$changed(REF_VPOS) |-> REF_CAPTURE || $past(REF_CAPTURE))
		else $error("reference position moved without capture");
	a_mean_alone: assert property (
		MEAN_PUBLISH |-> !RESULT_UPDATE)
		else $error("update beside average publish");

	c_publish: cover property (MEAN_PUBLISH);
	c_clear: cover property (RESULT_CLEAR);
	c_freeze: cover property ($fell(ACQ_RUN));
	c_capture: cover property (REF_CAPTURE);
endmodule

// [verif/wac_sweep_model.sv]
// Sweep gate model that ends one acquired sweep per request
`timescale 1ns/1ps
module wac_sweep_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       go,
	input  wire logic [3:0] gap,
	output logic            sweep_end,
	output logic            busy
);
	logic [4:0] cnt_r;
	logic [4:0] last_r;

	// Four cycles high then at least four low, so every edge survives the pin synchroniser
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= 5'h00;
			last_r <= 5'h08;
		end else if (go && cnt_r == 5'h00) begin
			cnt_r  <= 5'h01;
			last_r <= 5'h08 + 5'(gap);
		end else if (cnt_r != 5'h00) begin
			cnt_r <= (cnt_r >= last_r) ? 5'h00 : cnt_r + 5'h01;
		end
	end

	// Gate idles low between sweeps, as the real gate does
	assign sweep_end = (cnt_r != 5'h00) && (cnt_r <= 5'h04);
	assign busy      = (cnt_r != 5'h00);
endmodule

// [verif/testbench.sv]
// Self-checking bench for the accumulation control block
`timescale 1ns/1ps
module testbench;
	import wac_pkg::*;
	localparam int          REC_LEN = 512;
	localparam logic [31:0] FS      = 32'h30;
	logic              clk_sys, rstn, wr_s, rd_s, go;
	logic [3:0]        gap;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic              acq_run, res_upd, res_clr, mean_pub, disp_own, ref_cap, ref_show, interp, swp;
	logic [9:0]        pretrig;
	logic [15:0]       disp_val;
	logic [7:0]        ref_vpos, ref_hpos;
	logic [6:0]        hexp_c, hexp_f;
	logic [3:0]        vexp_f;
	int                err_count, compares, seed, m_exp, m_mode, n_upd, n_clr, n_pub, n_cap;
	logic [31:0]       ctl;

	wac_top #(.REC_LEN(REC_LEN)) u_wac_top (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .SWEEP_END(swp), .ACQ_RUN(acq_run), .RESULT_UPDATE(res_upd),
		.RESULT_CLEAR(res_clr), .MEAN_PUBLISH(mean_pub), .PRETRIG_CNT(pretrig), .DISP_VALUE(disp_val),
		.DISP_COUNT_OWN(disp_own), .REF_CAPTURE(ref_cap), .REF_SHOW(ref_show), .REF_VPOS(ref_vpos),
		.REF_HPOS(ref_hpos), .INTERP_SMOOTH(interp), .HEXP_CENTER(hexp_c), .HEXP_FACTOR(hexp_f),
		.VEXP_FACTOR(vexp_f));
	wac_sweep_model u_wac_sweep_model (.clk(clk_sys), .rstn(rstn), .go(go), .gap(gap), .sweep_end(swp),
		.busy());

	// Clock at 100 MHz
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Result pulse tallies; update, clear and publish counts are compared as differences, the capture count as a running total
	always @(posedge clk_sys) begin
		if (res_upd === 1'b1) n_upd++;
		if (res_clr === 1'b1) n_clr++;
		if (mean_pub === 1'b1) n_pub++;
		if (ref_cap === 1'b1) n_cap++;
	end

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
		compares++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, msg, got, want);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic ctlw(input logic [31:0] v);
		ctl = v;
		wr(REG_CTRL, v);
		idle(3);
	endtask

	// Reference model of the count selection; knob steps clamp at each mode's limits, a mode switch only at the averaging limits
	task automatic setmode(input int m, input logic [31:0] bits);
		m_mode = m;
		if (m == 2 && m_exp > 8) m_exp = 8;
		if (m == 2 && m_exp < 1) m_exp = 1;
		ctlw(bits | 32'(m));
	endtask

	task automatic knob(input bit cw);
		int lo;
		int hi;
		lo = (m_mode == 2) ? 1 : 0;
		hi = (m_mode == 1) ? 9 : 8;
		m_exp = cw ? ((m_exp < hi) ? m_exp + 1 : hi) : ((m_exp > lo) ? m_exp - 1 : lo);
		wr(REG_KNOB, cw ? 32'h1 : 32'h2);
		idle(3);
	endtask

	function automatic int m_disp();
		return (m_exp == 9) ? 9999 : (1 << m_exp);
	endfunction

	// Slow or prompt sweeps from the gate model, then time for the result pulses to land
	task automatic sweep(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			go  <= 1'b1;
			gap <= 4'($random(seed));
			@(posedge clk_sys);
			go <= 1'b0;
			#1 k = 0;
			while (swp === 1'b1 || u_wac_sweep_model.busy === 1'b1) begin
				@(posedge clk_sys);
				k++;
				if (k > 40) begin
					chk(1'b0, 1'b1, "sweep gate hung");
					tally_and_finish();
				end
			end
			idle(8);
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [7:0]  v1;
		int          u0, c0, p0;
		seed = 32'h30e392a8;
		{rstn, wr_s, rd_s, go, gap, addr, wdata} = '0;
		m_exp = 5;
		m_mode = 0;
		idle(2);
		rstn <= 1'b1;
		idle(2);
		rd(REG_STATUS, d);
		chk(d[12:9], 32'h5, "power-on exponent");
		chk(disp_val, 32'h20, "power-on count");
		rd(8'h20, d);
		chk(d, 32'h0, "unmapped read");
		for (int w = 0; w < 2; w++) begin
			ctlw(32'(w) << 2);
			rd(REG_WINDOW, d);
			chk(d, w ? REC_LEN / 8 : REC_LEN * 7 / 8, "window register");
			chk(pretrig, w ? REC_LEN / 8 : REC_LEN * 7 / 8, "window port");
		end
		for (int m = 2; m > 0; m--) begin
			setmode(m, FS);
			chk(interp, m == 2, "interpolation");
			for (int i = 0; i < 20; i++) begin
				knob(i >= 10);
				rd(REG_STATUS, d);
				chk(d[12:9], m_exp, "knob exponent");
				chk(disp_val, m_disp(), "knob display");
			end
		end
		wr(REG_KNOB, 32'h3);
		rd(REG_STATUS, d);
		chk(d[12:9], m_exp, "double knob ignored");
		u0 = n_upd;
		c0 = n_clr;
		sweep(3);
		chk(n_upd - u0, 3, "unlimited updates");
		chk(n_clr - c0, 0, "unlimited clears");
		chk(disp_val, 16'h270f, "unlimited display");
		ctlw(FS | 32'h41);
		chk(acq_run, 1'b0, "unlimited freeze");
		wr(REG_EXPAND, 32'h37f);
		idle(3);
		chk(hexp_f, 7'h64, "horizontal clamp");
		chk(vexp_f, 4'h3, "vertical factor");
		chk(hexp_c, 7'h40, "late centre");
		ctlw(FS);
		ctlw(FS | 32'h48);
		chk(acq_run, 1'b0, "live freeze");
		chk(hexp_c, 7'h20, "chop centre");
		wr(REG_EXPAND, 32'hf00);
		idle(3);
		chk(hexp_f, 7'h1, "horizontal floor");
		chk(vexp_f, 4'ha, "vertical clamp");
		setmode(2, FS | 32'h100);
		repeat (7) knob(1'b0);
		p0 = n_pub;
		sweep(1);
		chk(disp_val, 16'h1, "countdown while held");
		ctlw(FS | 32'h2);
		chk(disp_own, 1'b1, "display owned after release");
		sweep(2);
		chk(n_pub - p0, 1, "first average");
		chk(disp_own, 1'b0, "display handed back");
		sweep(4);
		chk(n_pub - p0, 3, "repeating average");
		wr(REG_CHANGE, 32'h1);
		idle(3);
		rd(REG_STATUS, d);
		chk(d[8:0], 9'h0, "change restarts");
		p0 = n_pub;
		sweep(1);
		chk(n_pub - p0, 0, "no early average");
		sweep(1);
		chk(n_pub - p0, 1, "average after restart");
		ctlw(FS | 32'h42);
		chk(acq_run, 1'b1, "freeze pending");
		sweep(1);
		wr(REG_CHANGE, 32'h1);
		idle(3);
		rd(REG_STATUS, d);
		chk(d[8:0], 9'h0, "pending cycle restart");
		chk(d[15], 1'b1, "still pending");
		sweep(1);
		chk(acq_run, 1'b1, "restarted cycle runs");
		sweep(1);
		chk(acq_run, 1'b0, "stop at cycle end");
		chk(n_pub - p0, 2, "final average kept");
		setmode(1, FS);
		u0 = n_upd;
		c0 = n_clr;
		sweep(4);
		chk(n_upd - u0, 4, "envelope updates");
		chk(n_clr - c0, 2, "envelope clears");
		v1 = 8'($random(seed));
		wr(REG_POS, {16'h0, v1, 8'h11});
		ctlw(FS | 32'h81);
		chk(ref_show, 1'b1, "reference shown");
		chk(ref_vpos, v1, "reference position");
		chk(n_cap, 1, "first capture");
		wr(REG_POS, {16'h0, v1 ^ 8'h5a, 8'h22});
		idle(3);
		chk(ref_vpos, v1, "position kept");
		chk(ref_hpos, 8'h22, "horizontal follows");
		ctlw(FS | 32'h1);
		chk(ref_show, 1'b0, "reference removed");
		ctlw(FS | 32'h81);
		chk(ref_vpos, v1 ^ 8'h5a, "new capture");
		chk(n_cap, 2, "second capture");
		tally_and_finish();
	end
endmodule

bind wac_top wac_top_sva #(.REC_LEN(REC_LEN), .REC_W(REC_W)) u_wac_top_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.WR(WR), .ACQ_RUN(ACQ_RUN), .RESULT_UPDATE(RESULT_UPDATE), .RESULT_CLEAR(RESULT_CLEAR),
	.MEAN_PUBLISH(MEAN_PUBLISH), .PRETRIG_CNT(PRETRIG_CNT), .DISP_VALUE(DISP_VALUE), .REF_CAPTURE(REF_CAPTURE),
	.REF_VPOS(REF_VPOS), .HEXP_CENTER(HEXP_CENTER), .HEXP_FACTOR(HEXP_FACTOR), .VEXP_FACTOR(VEXP_FACTOR));
